// ===== rmc_caches.sv
// Context-cache and PASID-cache with miss walk, fault gating and invalidation.
// Assumes the walker and the translation path share pclk; APB for registers.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rmc_caches #(
  parameter int CTX_ENTRIES = 4,
  parameter int PAS_ENTRIES = 4,
  parameter bit CM_SUPPORTED = 1'b0
) (
  input wire logic pclk,  // Clock
  input wire logic presetn,  // Async reset, low
  input wire logic psel,  // APB select
  input wire logic penable,  // APB access phase
  input wire logic pwrite,  // APB write
  input wire logic [rmc_pkg::PADDR_W-1:0] paddr,  // APB address
  input wire logic [31:0] pwdata,  // APB write data
  output logic [31:0] prdata,  // APB read data
  output logic pready,  // APB ready
  output logic pslverr,  // APB error, unmapped address
  input wire logic req_valid,  // Translation lookup request
  output logic req_ready,  // Lookup accepted
  input wire logic [rmc_pkg::SID_W-1:0] req_source_id,  // Requester source id
  input wire logic req_with_pasid,  // Request carries a PASID
  input wire logic [rmc_pkg::PASID_W-1:0] req_pasid,  // Request PASID
  output logic rsp_valid,  // Answer pulse
  output logic rsp_fault,  // Answer is a fault
  output logic [rmc_pkg::CTX_W-1:0] rsp_ctx_entry,  // Context payload
  output logic [rmc_pkg::PAS_W-1:0] rsp_pasid_entry,  // PASID payload
  output logic [rmc_pkg::DOM_W-1:0] rsp_domain,  // Tag for downstream caches
  output logic walk_req,  // Table fetch request, held to done
  output logic [rmc_pkg::SID_W-1:0] walk_source_id,  // Fetch source id
  output logic [rmc_pkg::PASID_W-1:0] walk_pasid,  // Fetch PASID
  output logic walk_need_pasid,  // PASID entry is wanted too
  input wire logic walk_done,  // Fetch finished, results valid
  input wire logic [rmc_pkg::CTX_W-1:0] walk_ctx_entry,  // Fetched context
  input wire logic [rmc_pkg::PAS_W-1:0] walk_pasid_entry,  // Fetched PASID entry
  input wire logic walk_mem_err,  // Memory error on a fetch
  input wire logic walk_root_present,  // Root entry present
  input wire logic walk_root_invalid,  // Root entry badly programmed
  input wire logic walk_root_rsvd,  // Root reserved bits nonzero
  input wire logic walk_ctx_present,  // Context entry present
  input wire logic walk_ctx_invalid,  // Context badly programmed
  input wire logic walk_ctx_rsvd,  // Context reserved bits nonzero
  input wire logic walk_nest_ptb_fault,  // PASID table base translation fault
  input wire logic walk_nest_pstb_fault,  // PASID state base translation fault
  input wire logic walk_pasid_present,  // PASID entry present
  input wire logic walk_pasid_invalid,  // PASID entry badly programmed
  input wire logic walk_pasid_rsvd,  // PASID reserved bits nonzero
  input wire logic walk_nest_flroot_fault,  // First-level root translation fault
  input wire logic inv_valid,  // Invalidation request, held to done
  input wire logic [2:0] inv_kind,  // Invalidation selector
  input wire logic [rmc_pkg::SID_W-1:0] inv_source_id,  // Source id to drop
  input wire logic [rmc_pkg::DOM_W-1:0] inv_domain,  // Domain to drop
  input wire logic [rmc_pkg::PASID_W-1:0] inv_pasid,  // PASID to drop
  output logic inv_done  // Invalidation complete pulse
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_LKC = 5'b00010,
    S_LKP = 5'b00100,
    S_WALK = 5'b01000,
    S_INV = 5'b10000
  } rmc_state_t;

  rmc_state_t state;  // Current state
  rmc_state_t next_state;  // Next state
  logic [rmc_pkg::CTRL_W-1:0] ctrl;  // Control register
  logic [31:0] ctx_hits;  // Context hit counter
  logic [31:0] pas_hits;  // PASID hit counter
  logic [31:0] faults;  // Faulting walk counter
  logic cur_wp;  // Latched with-PASID flag
  logic ctx_missed;  // Context came from the walk
  logic [2:0] cur_kind;  // Latched invalidation kind
  logic [rmc_pkg::SID_W-1:0] cur_isid;  // Latched inval source id
  logic [rmc_pkg::DOM_W-1:0] cur_idom;  // Latched inval domain
  logic [rmc_pkg::PASID_W-1:0] cur_ipasid;  // Latched inval PASID
  logic [rmc_pkg::CTX_W-1:0] cur_ctx;  // Context from a hit
  logic c_hit;  // Context store answer
  logic [rmc_pkg::CTX_W:0] c_data;  // Context payload plus fault bit
  logic p_hit;  // PASID store answer
  logic [rmc_pkg::PAS_W:0] p_data;  // PASID payload plus fault bit

  // APB decode
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pready && pwrite;
  wire hit_ctrl = paddr == rmc_pkg::REG_CTRL;
  wire hit_cap = paddr == rmc_pkg::REG_CAP;
  wire hit_ch = paddr == rmc_pkg::REG_CTX_HITS;
  wire hit_ph = paddr == rmc_pkg::REG_PAS_HITS;
  wire hit_fl = paddr == rmc_pkg::REG_FAULTS;
  wire mapped = hit_ctrl | hit_cap | hit_ch | hit_ph | hit_fl;
  wire cm = ctrl[rmc_pkg::CTRL_CM_BIT] & CM_SUPPORTED;
  wire ctx_en = ctrl[rmc_pkg::CTRL_CTX_EN_BIT];
  wire pas_en = ctrl[rmc_pkg::CTRL_PAS_EN_BIT];
  wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl) : hit_cap ? 32'(cm) : hit_ch ? ctx_hits :
                       hit_ph ? pas_hits : hit_fl ? faults : 32'h0000_0000;

  // Handshake decode
  wire take_req = (state == S_IDLE) && req_valid && req_ready;
  wire take_inv = (state == S_IDLE) && !req_valid && inv_valid && !inv_done;
  wire c_hit_ok = c_hit && ctx_en;
  wire p_hit_ok = p_hit && pas_en;
  wire [rmc_pkg::DOM_W-1:0] hit_dom = c_data[rmc_pkg::CTX_DOM_LSB +: rmc_pkg::DOM_W];

  // Walk result checks
  wire [rmc_pkg::CTX_W-1:0] w_ctx = walk_ctx_entry[rmc_pkg::CTX_EXT_BIT] ? walk_ctx_entry :
                                    walk_ctx_entry & rmc_pkg::CTX_PLAIN_MASK;
  wire w_nest = w_ctx[rmc_pkg::CTX_NEST_BIT];
  wire w_die = w_ctx[rmc_pkg::CTX_DIE_BIT];
  wire ctx_absent = walk_mem_err | !walk_root_present | !walk_ctx_present;
  wire ctx_fault = ctx_absent | walk_root_invalid | walk_root_rsvd | walk_ctx_invalid |
                   walk_ctx_rsvd | (w_nest & walk_nest_ptb_fault) |
                   (w_nest & w_die & walk_nest_pstb_fault);
  wire pas_absent = ctx_absent | !walk_pasid_present;
  wire pas_fault = ctx_fault | pas_absent | walk_pasid_invalid | walk_pasid_rsvd |
                   (w_nest & walk_nest_flroot_fault);
  wire ctx_cacheable = ctx_en && (!ctx_fault || cm);
  wire pas_cacheable = pas_en && (!pas_fault || cm);
  wire [rmc_pkg::DOM_W-1:0] w_dom = ctx_absent ? rmc_pkg::DOM_RESERVED :
                                    w_ctx[rmc_pkg::CTX_DOM_LSB +: rmc_pkg::DOM_W];
  // Cached copy carries the reserved domain when no present context existed
  wire [rmc_pkg::CTX_W-1:0] w_ctx_tag = ctx_absent ?
       {w_ctx[rmc_pkg::CTX_W-1:rmc_pkg::CTX_DOM_LSB+rmc_pkg::DOM_W], rmc_pkg::DOM_RESERVED,
        w_ctx[rmc_pkg::CTX_DOM_LSB-1:0]} : w_ctx;
  wire [rmc_pkg::DOM_W-1:0] p_fill_dom = pas_absent ? rmc_pkg::DOM_RESERVED : w_dom;
  wire [rmc_pkg::PASID_W-1:0] p_fill_key = pas_absent ? rmc_pkg::PASID_RESERVED : walk_pasid;
  wire walk_end = (state == S_WALK) && walk_done;
  wire c_fill = walk_end && ctx_missed && ctx_cacheable;
  wire p_fill = walk_end && cur_wp && pas_cacheable;

  // Invalidation decode
  wire in_inv = state == S_INV;
  wire c_inv = in_inv && (cur_kind == rmc_pkg::INV_CTX_ALL || cur_kind == rmc_pkg::INV_CTX_SID ||
                          cur_kind == rmc_pkg::INV_CTX_DOM);
  wire p_inv = in_inv && (cur_kind == rmc_pkg::INV_PAS_ALL || cur_kind == rmc_pkg::INV_PAS_DOM ||
                          cur_kind == rmc_pkg::INV_PAS_PASID);
  wire p_inv_key = cur_kind == rmc_pkg::INV_PAS_PASID;
  wire p_inv_dom = p_inv_key || cur_kind == rmc_pkg::INV_PAS_DOM;

  // Context store, keyed by source id only
  rmc_entry_store #(
    .ENTRIES(CTX_ENTRIES),
    .KEY_W(rmc_pkg::SID_W),
    .DOM_W(rmc_pkg::DOM_W),
    .DATA_W(rmc_pkg::CTX_W + 1)
  ) u_ctx_store (
    .clk(pclk),
    .rst_n(presetn),
    .lk_en(take_req),
    .lk_key(req_source_id),
    .lk_dom(rmc_pkg::DOM_RESERVED),
    .lk_use_dom(1'b0),
    .lk_hit(c_hit),
    .lk_data(c_data),
    .fill_en(c_fill),
    .fill_key(walk_source_id),
    .fill_dom(w_dom),
    .fill_data({ctx_fault, w_ctx_tag}),
    .inv_en(c_inv),
    .inv_key(cur_isid),
    .inv_dom(cur_idom),
    .inv_use_key(cur_kind == rmc_pkg::INV_CTX_SID),
    .inv_use_dom(cur_kind == rmc_pkg::INV_CTX_DOM)
  );

  // PASID store, keyed by PASID and context domain
  rmc_entry_store #(
    .ENTRIES(PAS_ENTRIES),
    .KEY_W(rmc_pkg::PASID_W),
    .DOM_W(rmc_pkg::DOM_W),
    .DATA_W(rmc_pkg::PAS_W + 1)
  ) u_pas_store (
    .clk(pclk),
    .rst_n(presetn),
    .lk_en(state == S_LKC && c_hit_ok && cur_wp),
    .lk_key(walk_pasid),
    .lk_dom(hit_dom),
    .lk_use_dom(1'b1),
    .lk_hit(p_hit),
    .lk_data(p_data),
    .fill_en(p_fill),
    .fill_key(p_fill_key),
    .fill_dom(p_fill_dom),
    .fill_data({pas_fault, walk_pasid_entry}),
    .inv_en(p_inv),
    .inv_key(cur_ipasid),
    .inv_dom(cur_idom),
    .inv_use_key(p_inv_key),
    .inv_use_dom(p_inv_dom)
  );

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (take_req) begin
          next_state = S_LKC;
        end else if (take_inv) begin
          next_state = S_INV;
        end
      end
      S_LKC: begin
        if (!c_hit_ok) begin
          next_state = S_WALK;
        end else if (cur_wp) begin
          next_state = S_LKP;
        end else begin
          next_state = S_IDLE;
        end
      end
      S_LKP: next_state = p_hit_ok ? S_IDLE : S_WALK;
      S_WALK: next_state = walk_done ? S_IDLE : S_WALK;
      S_INV: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // State and request latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      req_ready <= 1'b1;
      cur_wp <= 1'b0;
      ctx_missed <= 1'b0;
      cur_ctx <= '0;
    end else begin
      state <= next_state;
      req_ready <= next_state == S_IDLE;
      if (take_req) begin
        cur_wp <= req_with_pasid;
      end
      if (state == S_LKC) begin
        ctx_missed <= !c_hit_ok;
        cur_ctx <= c_data[rmc_pkg::CTX_W-1:0];
      end
    end
  end

  // Walk port, held until the walker reports done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      walk_req <= 1'b0;
      walk_source_id <= '0;
      walk_pasid <= '0;
      walk_need_pasid <= 1'b0;
    end else begin
      if (take_req) begin
        walk_source_id <= req_source_id;
        walk_pasid <= req_pasid;
        walk_need_pasid <= req_with_pasid;
      end
      walk_req <= next_state == S_WALK;
    end
  end

  // Answer to the translation path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid <= 1'b0;
      rsp_fault <= 1'b0;
      rsp_ctx_entry <= '0;
      rsp_pasid_entry <= '0;
      rsp_domain <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (state == S_LKC && c_hit_ok && !cur_wp) begin
        rsp_valid <= 1'b1;
        rsp_fault <= c_data[rmc_pkg::CTX_W];
        rsp_ctx_entry <= c_data[rmc_pkg::CTX_W-1:0];
        rsp_pasid_entry <= '0;
        rsp_domain <= hit_dom;
      end else if (state == S_LKP && p_hit_ok) begin
        rsp_valid <= 1'b1;
        rsp_fault <= p_data[rmc_pkg::PAS_W];
        rsp_ctx_entry <= cur_ctx;
        rsp_pasid_entry <= p_data[rmc_pkg::PAS_W-1:0];
        rsp_domain <= cur_ctx[rmc_pkg::CTX_DOM_LSB +: rmc_pkg::DOM_W];
      end else if (walk_end) begin
        rsp_valid <= 1'b1;
        rsp_fault <= cur_wp ? pas_fault : ctx_fault;
        rsp_ctx_entry <= w_ctx_tag;
        rsp_pasid_entry <= walk_pasid_entry;
        rsp_domain <= w_dom;
      end
    end
  end

  // Invalidation latches and completion after the stores have dropped matches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_kind <= rmc_pkg::INV_CTX_ALL;
      cur_isid <= '0;
      cur_idom <= '0;
      cur_ipasid <= '0;
      inv_done <= 1'b0;
    end else begin
      if (take_inv) begin
        cur_kind <= inv_kind;
        cur_isid <= inv_source_id;
        cur_idom <= inv_domain;
        cur_ipasid <= inv_pasid;
      end
      inv_done <= in_inv;
    end
  end

  // Register file and APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= rmc_pkg::CTRL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= !mapped;
      end
      if (apb_wr && hit_ctrl) begin
        ctrl <= pwdata[rmc_pkg::CTRL_W-1:0];
      end
    end
  end

  // Activity counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctx_hits <= 32'h0000_0000;
      pas_hits <= 32'h0000_0000;
      faults <= 32'h0000_0000;
    end else begin
      if (state == S_LKC && c_hit_ok) begin
        ctx_hits <= ctx_hits + 32'h0000_0001;
      end
      if (state == S_LKP && p_hit_ok) begin
        pas_hits <= pas_hits + 32'h0000_0001;
      end
      if (walk_end && (cur_wp ? pas_fault : ctx_fault)) begin
        faults <= faults + 32'h0000_0001;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rmc_pkg.sv
// Shared constants of the context and PASID caches: widths, field layouts,
// register map and invalidation encodings.
// Assumes a single clock domain; nothing here is synthesised on its own.
package rmc_pkg;
  // Key, tag and address widths
  localparam int SID_W = 16;  // Source identifier
  localparam int DOM_W = 16;  // Domain tag
  localparam int PASID_W = 20;  // Process address space id
  localparam int ADDR_W = 52;  // Table base address, 4 KiB aligned
  // Context entry layout, plain part
  localparam int CTX_SLROOT_LSB = 0;  // Second-level table root
  localparam int CTX_TT_LSB = 52;  // Translation type, 2 bits
  localparam int CTX_FPD_BIT = 54;  // Fault processing disable
  localparam int CTX_DOM_LSB = 55;  // Domain tag
  localparam int CTX_AW_LSB = 71;  // Domain address width, 3 bits
  localparam int CTX_EXT_BIT = 74;  // Entry is an extended one
  // Context entry layout, extended part
  localparam int CTX_PTB_LSB = 75;  // PASID table base
  localparam int CTX_PSTB_LSB = 127;  // PASID state table base
  localparam int CTX_PTS_LSB = 179;  // PASID table size, 4 bits
  localparam int CTX_PASIDEN_BIT = 183;  // PASID feature enable
  localparam int CTX_NEST_BIT = 184;  // Nesting enable
  localparam int CTX_PRE_BIT = 185;  // Page request enable
  localparam int CTX_DIE_BIT = 186;  // Deferred invalidate enable
  localparam int CTX_ERE_BIT = 187;  // PASID exec request enable
  localparam int CTX_SECOND_LEVEL_EXEC_ENABLE_BIT = 188;  // Second level exec enable
  localparam int CTX_PGE_BIT = 189;  // Global page enable
  localparam int CTX_NXE_BIT = 190;  // No execute enable
  localparam int CTX_WPE_BIT = 191;  // Write protect enable
  localparam int CTX_SUPERVISOR_EXEC_PREVENTION_BIT = 192;  // Supervisor exec prevention
  localparam int CTX_CD_BIT = 193;  // Cache disable
  localparam int CTX_PAT_BIT = 194;  // Page attribute table use
  localparam int CTX_EXTENDED_MEMTYPE_ENABLE_BIT = 195;  // Extended memtype enable
  localparam int CTX_EMT_LSB = 196;  // Extended memory type, 3 bits
  localparam int CTX_W = 199;  // Whole context payload
  // Plain entries keep only the bits below the extended part
  localparam logic [CTX_W-1:0] CTX_PLAIN_MASK = {{(CTX_W-CTX_PTB_LSB){1'b0}}, {CTX_PTB_LSB{1'b1}}};
  // PASID entry layout
  localparam int PAS_FLROOT_LSB = 0;  // First-level table root
  localparam int PAS_PCD_BIT = 52;  // Page cache disable
  localparam int PAS_PWT_BIT = 53;  // Page write through
  localparam int PAS_SRE_BIT = 54;  // Supervisor request enable
  localparam int PAS_W = 55;  // Whole PASID payload
  // Register map, byte addresses
  localparam int PADDR_W = 12;
  localparam logic [PADDR_W-1:0] REG_CTRL = 12'h000;  // Cache enables, caching mode request
  localparam logic [PADDR_W-1:0] REG_CAP = 12'h004;  // Reported caching mode
  localparam logic [PADDR_W-1:0] REG_CTX_HITS = 12'h008;  // Context hit count
  localparam logic [PADDR_W-1:0] REG_PAS_HITS = 12'h00C;  // PASID hit count
  localparam logic [PADDR_W-1:0] REG_FAULTS = 12'h010;  // Faulting walk count
  localparam int CTRL_CTX_EN_BIT = 0;
  localparam int CTRL_PAS_EN_BIT = 1;
  localparam int CTRL_CM_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h3;
  localparam logic [DOM_W-1:0] DOM_RESERVED = 16'h0000;  // Tag for absent context
  localparam logic [PASID_W-1:0] PASID_RESERVED = 20'h0_0000;  // Tag for absent PASID entry
  // Invalidation kinds
  typedef enum logic [2:0] {
    INV_CTX_ALL = 3'h0,
    INV_CTX_SID = 3'h1,
    INV_CTX_DOM = 3'h2,
    INV_PAS_ALL = 3'h3,
    INV_PAS_DOM = 3'h4,
    INV_PAS_PASID = 3'h5
  } rmc_inv_kind_t;
endpackage

// ===== rmc_entry_store.sv
// Small fully associative entry store with key, domain tag and payload.
// Assumes one client at a time: lookup, fill and invalidate never coincide.
`timescale 1ns/1ps
`default_nettype none
module rmc_entry_store #(
  parameter int ENTRIES = 4,
  parameter int KEY_W = 16,
  parameter int DOM_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic clk,  // Clock
  input wire logic rst_n,  // Async reset, low
  input wire logic lk_en,  // Lookup strobe
  input wire logic [KEY_W-1:0] lk_key,  // Lookup key
  input wire logic [DOM_W-1:0] lk_dom,  // Lookup domain
  input wire logic lk_use_dom,  // Domain takes part in match
  output logic lk_hit,  // Hit, cycle after strobe
  output logic [DATA_W-1:0] lk_data,  // Hit payload
  input wire logic fill_en,  // Allocate strobe
  input wire logic [KEY_W-1:0] fill_key,  // New key
  input wire logic [DOM_W-1:0] fill_dom,  // New domain tag
  input wire logic [DATA_W-1:0] fill_data,  // New payload
  input wire logic inv_en,  // Invalidate strobe
  input wire logic [KEY_W-1:0] inv_key,  // Key to drop
  input wire logic [DOM_W-1:0] inv_dom,  // Domain to drop
  input wire logic inv_use_key,  // Match on key
  input wire logic inv_use_dom  // Match on domain
);
  localparam int PTR_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  logic [ENTRIES-1:0] vld;  // Entry valid
  logic [KEY_W-1:0] key_q [ENTRIES];  // Stored keys
  logic [DOM_W-1:0] dom_q [ENTRIES];  // Stored domains
  logic [DATA_W-1:0] data_q [ENTRIES];  // Stored payloads
  logic [ENTRIES-1:0] lk_match;  // Lookup match vector
  logic [ENTRIES-1:0] inv_match;  // Invalidate match vector
  logic [PTR_W-1:0] rr_ptr;  // Round robin victim
  logic [PTR_W-1:0] victim;  // Chosen slot
  logic [DATA_W-1:0] sel_data;  // Matching payload

  // Per-entry compare
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_cmp
      assign lk_match[g] = vld[g] && key_q[g] == lk_key && (!lk_use_dom || dom_q[g] == lk_dom);
      assign inv_match[g] = vld[g] && (!inv_use_key || key_q[g] == inv_key) &&
                            (!inv_use_dom || dom_q[g] == inv_dom);
    end
  endgenerate

  // Payload select and victim choice, free slot first
  always_comb begin
    sel_data = '0;
    victim = rr_ptr;
    for (int i = 0; i < ENTRIES; i++) begin
      if (lk_match[i]) begin
        sel_data = sel_data | data_q[i];
      end
    end
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (!vld[i]) begin
        victim = PTR_W'(i);
      end
    end
  end

  // Valid bits, pointer and registered lookup answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vld <= '0;
      rr_ptr <= '0;
      lk_hit <= 1'b0;
      lk_data <= '0;
    end else begin
      if (inv_en) begin
        vld <= vld & ~inv_match;
      end
      if (fill_en) begin
        vld[victim] <= 1'b1;
        rr_ptr <= PTR_W'(rr_ptr + 1'b1);
      end
      if (lk_en) begin
        lk_hit <= |lk_match;
        lk_data <= sel_data;
      end
    end
  end

  // Entry contents need no reset
  always_ff @(posedge clk) begin
    if (fill_en) begin
      key_q[victim] <= fill_key;
      dom_q[victim] <= fill_dom;
      data_q[victim] <= fill_data;
    end
  end
endmodule
`default_nettype wire

// ===== rmc_caches_monitor.sv
// Checker for the cache block: APB timing, lookup, walk and invalidation handshakes.
// Assumes it is bound to rmc_caches and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rmc_caches_monitor (
  input wire logic pclk, presetn, psel, penable, pready, pslverr, // Clock, reset, APB
  input wire logic req_valid, req_ready, rsp_valid, walk_req, walk_done, inv_valid, inv_done, // Handshakes
  input wire logic [rmc_pkg::PADDR_W-1:0] paddr, // APB address
  input wire logic [31:0] prdata // APB read data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_ready: assert property (psel && !penable |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_unmapped_err: assert property (pready && paddr > 12'h010 |-> pslverr && prdata == 0) else $error("no slverr");
  a_walk_hold: assert property (walk_req && !walk_done |=> walk_req) else $error("walk dropped");
  a_walk_answer: assert property (walk_req && walk_done |=> rsp_valid && !walk_req) else $error("no answer");
  a_one_request: assert property (req_valid && req_ready |=> !req_ready) else $error("second take");
  a_rsp_idle: assert property (rsp_valid |-> req_ready) else $error("busy at answer");
  a_inv_cause: assert property (inv_done |-> $past(inv_valid, 2)) else $error("stray inv_done");
  a_lookup_time: assert property (req_valid && req_ready && !walk_req |-> ##[2:3] (rsp_valid || walk_req))
    else $error("lookup stalled");
endmodule
bind rmc_caches rmc_caches_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .req_valid,
  .req_ready, .rsp_valid, .walk_req, .walk_done, .inv_valid, .inv_done, .paddr, .prdata);
`default_nettype wire

// ===== rmc_walk_model.sv
// Table walker model: answers each walk after a latency taken from the source id.
// Assumes walk_req is held until walk_done is seen.
`timescale 1ns/1ps
`default_nettype none
module rmc_walk_model (
  input wire logic pclk, presetn, walk_req, // Clock, reset, fetch request
  input wire logic [15:0] sid, // Fetch source id
  input wire logic [19:0] pasid, // Fetch PASID
  input wire logic [3:0] fsel, // Fault to report, 0 none
  output logic walk_done, // Fetch finished pulse
  output logic [198:0] ctx, // Nested context, plain when sid bits 0 and 4 are both set
  output logic [54:0] pe, // PASID entry
  output logic [15:0] flt // One-hot fault flags
);
  logic [2:0] cnt; // Cycles waited
  wire logic go = walk_req && !walk_done; // Walk open
  // Done pulse after sid[2:0] idle cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      walk_done <= 1'b0;
    end else begin
      walk_done <= go && cnt == sid[2:0];
      cnt <= (go && cnt != sid[2:0]) ? cnt + 3'h1 : 3'h0;
    end
  end
  // Results read inverted outside the done cycle; second-level root equals the source id, first-level root the PASID
  // Plain entry when source id bits 0 and 4 are both set
  assign ctx = {199{!walk_done}} ^ (199'(sid) << 55 | 199'(sid) | 199'(!(sid[0] & sid[4])) << 74 | 199'(1) << 184 |
    199'(1) << 186);
  assign pe = {55{!walk_done}} ^ 55'(pasid);
  assign flt = {16{!walk_done}} ^ (16'h0001 << fsel);
endmodule
`default_nettype wire

// ===== rmc_caches_tb_top.sv
// Testbench: APB register access, lookups with walks, faults and invalidations.
// Assumes the walker model on the far side.
`timescale 1ns/1ps
`default_nettype none
module rmc_caches_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req_valid = 0, req_with_pasid = 0, inv_valid = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] req_source_id = 0, inv_source_id = 0, inv_domain = 0, wsid, rdom, flt;
  logic [19:0] req_pasid = 0, inv_pasid = 0, wpas;
  logic [2:0] inv_kind = 0;
  logic [3:0] fsel = 0;
  logic [198:0] wctx, rctx;
  logic [54:0] write_protect_enable, rpe;
  logic pready, pslverr, req_ready, rsp_valid, rsp_fault, walk_req, wneed, wdone, inv_done, er;
  int n_fail = 0, n_checks = 0, n_walk = 0, i;
  initial forever #20 pclk = ~pclk;
  rmc_caches dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .req_valid, .req_ready, .req_source_id, .req_with_pasid, .req_pasid, .rsp_valid, .rsp_fault,
    .rsp_ctx_entry(rctx), .rsp_pasid_entry(rpe), .rsp_domain(rdom), .walk_req, .walk_source_id(wsid),
    .walk_pasid(wpas), .walk_need_pasid(wneed), .walk_done(wdone), .walk_ctx_entry(wctx), .walk_pasid_entry(write_protect_enable),
    .walk_mem_err(flt[1]), .walk_ctx_present(!flt[2]), .walk_ctx_invalid(flt[3]), .walk_ctx_rsvd(flt[4]),
    .walk_nest_ptb_fault(flt[5]), .walk_pasid_present(!flt[6]), .walk_nest_flroot_fault(flt[7]),
    .walk_root_present(!flt[8]), .walk_root_invalid(flt[9]), .walk_root_rsvd(flt[10]), .walk_nest_pstb_fault(flt[11]),
    .walk_pasid_invalid(flt[12]), .walk_pasid_rsvd(flt[13]), .inv_valid, .inv_kind, .inv_source_id, .inv_domain,
    .inv_pasid, .inv_done);
  rmc_walk_model wm (.pclk, .presetn, .walk_req, .sid(wsid), .pasid(wpas), .fsel, .walk_done(wdone), .ctx(wctx),
    .pe(write_protect_enable), .flt);
  // Completed walks
  always @(posedge pclk) if (walk_req && wdone) n_walk <= n_walk + 1;
  task complete_run;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [198:0] s, x);
    n_checks++;
    if (s !== x) begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, x, s);
    end
  endtask
  task tmo;
    if (i >= 99) begin
      n_fail++;
      complete_run();
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1;
    i = 0;
    do @(posedge pclk) i++; while (pready !== 1 && i < 99);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    tmo();
  endtask
  // One lookup; xw says whether a walk is expected, xf a fault
  task look(input logic [15:0] sid, input logic wp, input logic [19:0] ps, input logic xw, xf);
    int w0;
    w0 = n_walk;
    @(posedge pclk) {req_valid, req_source_id, req_with_pasid, req_pasid} <= {1'b1, sid, wp, ps};
    i = 0;
    do @(posedge pclk) i++; while (req_ready !== 1 && i < 99);
    req_valid <= 0;
    do @(posedge pclk) i++; while (rsp_valid !== 1 && i < 99);
    tmo();
    chk("walk", n_walk != w0, xw);
    chk("fault", rsp_fault, xf);
    chk("need pasid", wneed, wp);
    if (!xf) chk("context", rctx, {(sid[0] & sid[4]) ? 124'h0 : 124'h5 << 109, !(sid[0] & sid[4]), 3'h0, sid,
      55'(sid)});
    if (!xf) chk("domain", rdom, sid);
    if (!xf && wp) chk("pasid entry", rpe, 55'(ps));
  endtask
  task inv(input logic [2:0] k, input logic [15:0] s, d, input logic [19:0] p);
    @(posedge pclk) {inv_valid, inv_kind, inv_source_id, inv_domain, inv_pasid} <= {1'b1, k, s, d, p};
    i = 0;
    do @(posedge pclk) i++; while (inv_done !== 1 && i < 99);
    inv_valid <= 0;
    tmo();
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, rmc_pkg::REG_CTRL, 0); chk("ctrl", rd, 32'h0000_0003);
    apb(1, rmc_pkg::REG_CTRL, 32'h0000_0007);
    apb(0, rmc_pkg::REG_CAP, 0); chk("cap", rd, 32'h0000_0000);
    apb(0, 12'h020, 0); chk("slverr", er, 1'b1);
    for (int f = 1; f < 14; f++) begin
      fsel <= 4'(f);
      repeat (2) look(16'(16'h0100 + f), 1, 20'(f), 1, 1);
    end
    fsel <= 0;
    apb(0, rmc_pkg::REG_FAULTS, 0); chk("faults", rd, 32'h0000_001A);
    look(16'h0012, 0, 0, 1, 0);
    look(16'h0012, 0, 0, 0, 0);
    look(16'h0012, 1, 20'h0_0005, 1, 0);
    look(16'h0012, 1, 20'h0_0005, 0, 0);
    inv(rmc_pkg::INV_PAS_PASID, 0, 16'h0012, 20'h0_0005);
    look(16'h0012, 1, 20'h0_0005, 1, 0);
    inv(rmc_pkg::INV_CTX_SID, 16'h0012, 0, 0);
    look(16'h0012, 0, 0, 1, 0);
    for (int k = 0; k < 8; k++) inv(3'(k), 16'h0012, 16'h0012, 20'h0_0005);
    look(16'h0012, 0, 0, 1, 0);
    apb(1, rmc_pkg::REG_CTRL, 0);
    repeat (2) look(16'h0013, 0, 0, 1, 0);
    complete_run();
  end
endmodule
`default_nettype wire
